// ### rtl/sdisel_top.sv
// Status LED selector and pattern controls for the video demo board
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
// Notes on behaviour
// - select 00 shows first receiver state
// - select 01 shows second receiver state
// - select 10 shows both receive standards
// - standard pair: first LED high bit
// - select 11 shows generator standard on D9/D10
// - switch OFF reads 1, ON reads 0
// - low switch bits pick generator standard
// - receive bi-colour LEDs show detected standard
// - transmit bi-colour LEDs show sent standard
// - default 75% bar, first button 100%
// - second button selects checkfield pattern
// - third button resets the pattern logic
module sdisel_top
   import sdisel_pkg::*;
(
   input wire logic clk_i, // 250 MHz system clock
   input wire logic rst_i, // Synchronous, active high
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [3:0] user_switch_field_i, // OFF = 1, ON = 0
   input wire logic full_colorbar_button_n_i, // Low when pressed
   input wire logic checkfield_button_n_i, // Low when pressed
   input wire logic logic_reset_button_n_i, // Low when pressed
   input wire logic [3:0] first_input_rx_state_i, // {align,trs,frame,reset}
   input wire logic [3:0] second_input_rx_state_i,
   input wire logic [1:0] first_input_rx_standard_i,
   input wire logic [1:0] second_input_rx_standard_i,
   input wire logic [1:0] first_output_tx_standard_i,
   input wire logic [1:0] second_output_tx_standard_i,
   output logic [3:0] led_o, // [0]=D7 .. [3]=D10
   output logic [1:0] rx_first_bicolor_o, // D6 {green,red}
   output logic [1:0] rx_second_bicolor_o, // D1
   output logic [1:0] tx_first_bicolor_o, // D5
   output logic [1:0] tx_second_bicolor_o, // D3
   output logic [1:0] pattern_standard_o, // To generator
   output logic [1:0] pattern_select_o, // 75%, 100% or checkfield
   output logic logic_reset_o // Reset request to the logic
);
   // ==========================================================
   // Helper functions
   // Standard to bi-colour drive; unknown code stays dark
   function automatic logic [1:0] std_color(input logic [1:0] std);
      logic [1:0] col;
      col = SDISEL_COL_OFF;
      case (std)
         SDISEL_STD_3G: col = SDISEL_COL_GRN;
         SDISEL_STD_HD: col = SDISEL_COL_ORG;
         SDISEL_STD_SD: col = SDISEL_COL_RED;
         default: col = SDISEL_COL_OFF;
      endcase
      return col;
   endfunction : std_color

   // Standard to LED pair: [0] is the first LED, holding the high bit
   function automatic logic [1:0] std_pair(input logic [1:0] std);
      return {std[0], std[1]};
   endfunction : std_pair

   // ==========================================================
   // Input capture
   logic [3:0] sw_r; // Switch field, taken as the pin reads
   logic bar_prev_n_r; // Button levels one cycle back
   logic chk_prev_n_r;
   logic bar_press; // Falling edge of each pattern button
   logic chk_press;
   logic rst_btn; // Reset button held

   // Switch pin level is the logic value: OFF pulls high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_r <= SDISEL_SW_RST;
      end else begin
         sw_r <= user_switch_field_i;
      end
   end

   // Previous button levels for press detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bar_prev_n_r <= 1'b1;
         chk_prev_n_r <= 1'b1;
      end else begin
         bar_prev_n_r <= full_colorbar_button_n_i;
         chk_prev_n_r <= checkfield_button_n_i;
      end
   end

   // Pattern buttons act once, on their press edge; the reset button acts while held
   assign bar_press = bar_prev_n_r & ~full_colorbar_button_n_i;
   assign chk_press = chk_prev_n_r & ~checkfield_button_n_i;
   assign rst_btn = ~logic_reset_button_n_i;

   // ==========================================================
   // Wishbone slave
   logic ack_r; // Answer, one cycle after request
   logic [31:0] dat_r; // Read data
   logic [2:0] ctrl_r; // Control word
   logic wr_ctrl; // Write to control takes effect now
   logic [31:0] stat_word; // Status word as read

   // Writes land on the acknowledged edge only
   assign wr_ctrl = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0] &
                    (wb_adr_i == SDISEL_CTRL_OFS);

   // Answer every request after one wait cycle; drop in the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      end
   end

   // Read mux; unmapped addresses read as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= SDISEL_RD_ZERO;
      end else if (wb_adr_i == SDISEL_CTRL_OFS) begin
         dat_r <= {29'h0000_0000, ctrl_r};
      end else if (wb_adr_i == SDISEL_STAT_OFS) begin
         dat_r <= stat_word;
      end else begin
         dat_r <= SDISEL_RD_ZERO;
      end
   end

   // Control word; byte lane 0 carries every field
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= SDISEL_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= wb_dat_i[2:0];
      end
   end

   // ==========================================================
   // Pattern state machine
   sdisel_pat_type pat_r; // Current test pattern
   logic sw_rst; // Software reset bit

   // Pattern field acts on the write edge, so it is read from the bus, not ctrl_r
   assign sw_rst = ctrl_r[SDISEL_CTRL_RST_BIT];

   // Reset outranks buttons; buttons outrank software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pat_r <= SDISEL_PAT_BAR75;
      end else if (rst_btn | sw_rst) begin
         pat_r <= SDISEL_PAT_BAR75;
      end else if (chk_press) begin
         pat_r <= SDISEL_PAT_CHECK;
      end else if (bar_press) begin
         pat_r <= SDISEL_PAT_BAR100;
      end else if (wr_ctrl) begin
         // Software picks a pattern; unknown code is ignored
         case (wb_dat_i[SDISEL_CTRL_PAT_LSB +: 2])
            SDISEL_PAT_BAR75: pat_r <= SDISEL_PAT_BAR75;
            SDISEL_PAT_BAR100: pat_r <= SDISEL_PAT_BAR100;
            SDISEL_PAT_CHECK: pat_r <= SDISEL_PAT_CHECK;
            default: pat_r <= pat_r;
         endcase
      end
   end

   // ==========================================================
   // Output registers
   logic [1:0] std_sel; // Generator standard, fallback applied
   logic [3:0] led_nxt;

   // Code 10 is not a standard; send SD rather than garbage
   assign std_sel = (sw_r[1:0] == SDISEL_STD_HD) ? SDISEL_STD_HD :
                    (sw_r[1:0] == SDISEL_STD_3G) ? SDISEL_STD_3G :
                    SDISEL_STD_SD;

   // LED source picked by switch bits 3:2
   always_comb begin
      led_nxt = SDISEL_LED_RST;
      case (sw_r[3:2])
         SDISEL_SEL_RX1: led_nxt = first_input_rx_state_i;
         SDISEL_SEL_RX2: led_nxt = second_input_rx_state_i;
         SDISEL_SEL_STD: begin
            // D7/D8 second input, D9/D10 first input
            led_nxt = {std_pair(first_input_rx_standard_i),
                       std_pair(second_input_rx_standard_i)};
         end
         default: begin
            // D7/D8 stay dark in this mode
            led_nxt = {std_pair(pattern_standard_o), 2'h0};
         end
      endcase
   end

   // LED outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_o <= SDISEL_LED_RST;
      end else begin
         led_o <= led_nxt;
      end
   end

   // Bi-colour indicators follow the detected and sent standards
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_first_bicolor_o <= SDISEL_COL_OFF;
         rx_second_bicolor_o <= SDISEL_COL_OFF;
         tx_first_bicolor_o <= SDISEL_COL_OFF;
         tx_second_bicolor_o <= SDISEL_COL_OFF;
      end else begin
         rx_first_bicolor_o <= std_color(first_input_rx_standard_i);
         rx_second_bicolor_o <= std_color(second_input_rx_standard_i);
         tx_first_bicolor_o <= std_color(first_output_tx_standard_i);
         tx_second_bicolor_o <= std_color(second_output_tx_standard_i);
      end
   end

   // Generator controls and reset request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pattern_standard_o <= SDISEL_STD_SD;
         logic_reset_o <= 1'b0;
      end else begin
         pattern_standard_o <= std_sel;
         logic_reset_o <= rst_btn | sw_rst;
      end
   end

   assign pattern_select_o = pat_r;
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // Status word: live view of the block's state
   assign stat_word = {20'h0_0000, sw_r, pattern_standard_o, pat_r, led_o};

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_sw_capture: assert property (sw_r == $past(user_switch_field_i))
      else $error("switch field not taken as pin level");
   a_sel_first: assert property (sw_r[3:2] == SDISEL_SEL_RX1 |=>
      led_o == $past(first_input_rx_state_i))
      else $error("LEDs do not show first receiver state");
   a_sel_second: assert property (sw_r[3:2] == SDISEL_SEL_RX2 |=>
      led_o == $past(second_input_rx_state_i))
      else $error("LEDs do not show second receiver state");
   a_sel_std: assert property (sw_r[3:2] == SDISEL_SEL_STD |=>
      led_o[0] == $past(second_input_rx_standard_i[1]) &&
      led_o[1] == $past(second_input_rx_standard_i[0]) &&
      led_o[2] == $past(first_input_rx_standard_i[1]) &&
      led_o[3] == $past(first_input_rx_standard_i[0]))
      else $error("standard pair order wrong");
   a_sel_gen: assert property (sw_r[3:2] == SDISEL_SEL_TX |=>
      led_o[1:0] == 2'h0 && led_o[2] == $past(pattern_standard_o[1]) &&
      led_o[3] == $past(pattern_standard_o[0]))
      else $error("generator standard not on D9/D10");
   a_gen_std: assert property ($past(sw_r[1:0]) == 2'h2 |->
      pattern_standard_o == SDISEL_STD_SD)
      else $error("code 10 did not fall back to SD");
   a_gen_follow: assert property (sw_r[1:0] != 2'h2 |=>
      pattern_standard_o == $past(sw_r[1:0]))
      else $error("generator standard ignores switches");
   a_rx_color: assert property (first_input_rx_standard_i == SDISEL_STD_3G |=>
      rx_first_bicolor_o == SDISEL_COL_GRN)
      else $error("3G receive not green");
   a_tx_color: assert property (second_output_tx_standard_i == SDISEL_STD_SD |=>
      tx_second_bicolor_o == SDISEL_COL_RED)
      else $error("SD transmit not red");
   a_bar_press: assert property (bar_press && !chk_press && !rst_btn && !sw_rst |=>
      pattern_select_o == SDISEL_PAT_BAR100)
      else $error("first button did not select full bar");
   a_chk_press: assert property (chk_press && !rst_btn && !sw_rst |=>
      pattern_select_o == SDISEL_PAT_CHECK)
      else $error("second button did not select checkfield");
   a_reset_btn: assert property (rst_btn |=> logic_reset_o &&
      pattern_select_o == SDISEL_PAT_BAR75)
      else $error("reset button had no effect");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered after one wait cycle");
   a_soft_reset: assert property (sw_rst |=> logic_reset_o &&
      pattern_select_o == SDISEL_PAT_BAR75)
      else $error("software reset had no effect");

   c_bar_full: cover property (pattern_select_o == SDISEL_PAT_BAR100);
   c_checkfield: cover property (pattern_select_o == SDISEL_PAT_CHECK);
   c_std_view: cover property (sw_r[3:2] == SDISEL_SEL_STD ##1 led_o != 4'h0);
   c_bus_write: cover property (wr_ctrl);
   c_soft_reset: cover property (sw_rst ##1 logic_reset_o);
endmodule : sdisel_top

// ### rtl/sdisel_pkg.sv
// Constants shared by the status LED selector and its surroundings
package sdisel_pkg;
   // ==========================================================
   // Register map (byte addresses on the bus)
   localparam logic [3:0] SDISEL_CTRL_OFS = 4'h0; // Control word
   localparam logic [3:0] SDISEL_STAT_OFS = 4'h4; // Status word
   localparam logic [31:0] SDISEL_RD_ZERO = 32'h0000_0000; // Unmapped read
   // ==========================================================
   // Control register fields and reset value
   localparam int SDISEL_CTRL_PAT_LSB = 0; // Pattern request, 2 bits
   localparam int SDISEL_CTRL_RST_BIT = 2; // Software logic reset
   localparam logic [2:0] SDISEL_CTRL_RST = 3'h0; // Value after reset
   // ==========================================================
   // Status register fields
   localparam int SDISEL_STAT_LED_LSB = 0; // Four LED levels
   localparam int SDISEL_STAT_PAT_LSB = 4; // Pattern state
   localparam int SDISEL_STAT_STD_LSB = 6; // Pattern standard
   localparam int SDISEL_STAT_SW_LSB = 8; // Switch field
   // ==========================================================
   // Display-select codes on switch bits 3:2
   localparam logic [1:0] SDISEL_SEL_RX1 = 2'h0; // First input state
   localparam logic [1:0] SDISEL_SEL_RX2 = 2'h1; // Second input state
   localparam logic [1:0] SDISEL_SEL_STD = 2'h2; // Both rx standards
   localparam logic [1:0] SDISEL_SEL_TX = 2'h3; // Generator standard
   // ==========================================================
   // Video standard codes
   localparam logic [1:0] SDISEL_STD_SD = 2'h0; // Standard definition
   localparam logic [1:0] SDISEL_STD_HD = 2'h1; // High definition
   localparam logic [1:0] SDISEL_STD_3G = 2'h3; // 3-gigabit
   // ==========================================================
   // Bi-colour drive {green, red}
   localparam logic [1:0] SDISEL_COL_OFF = 2'h0; // Dark
   localparam logic [1:0] SDISEL_COL_RED = 2'h1; // Red
   localparam logic [1:0] SDISEL_COL_GRN = 2'h2; // Green
   localparam logic [1:0] SDISEL_COL_ORG = 2'h3; // Both: orange
   // ==========================================================
   // Reset values
   localparam logic [3:0] SDISEL_LED_RST = 4'h0; // LEDs dark
   localparam logic [3:0] SDISEL_SW_RST = 4'hF; // All switches OFF
   // ==========================================================
   // Test pattern states, Gray along the usual path
   typedef enum logic [1:0] {
      SDISEL_PAT_BAR75 = 2'h0,
      SDISEL_PAT_BAR100 = 2'h1,
      SDISEL_PAT_CHECK = 2'h3
   } sdisel_pat_type;
endpackage : sdisel_pkg

// ### test/sdisel_board.sv
// Board model: user switch bank and push buttons
`timescale 1ns/100ps
module sdisel_board (
   input wire logic [3:0] sw_on_i, // 1 = switch ON
   input wire logic [2:0] press_i, // 1 = button held
   output logic [3:0] user_switch_field_o,
   output logic full_colorbar_button_n_o,
   output logic checkfield_button_n_o,
   output logic logic_reset_button_n_o
);
   // ==========================================
   // ON grounds the pin, OFF is pulled high
   assign user_switch_field_o = ~sw_on_i;
   // Buttons short to ground while held, no bounce modelled
   assign full_colorbar_button_n_o = ~press_i[0];
   assign checkfield_button_n_o = ~press_i[1];
   assign logic_reset_button_n_o = ~press_i[2];
endmodule : sdisel_board

// ### test/sdisel_top_tb.sv
// Self-checking bench for the status LED selector
`timescale 1ns/100ps
module sdisel_top_tb;
   import sdisel_pkg::*;
   // ==========================================
   // Stimulus and observed nets
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0, sw_on = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, drd;
   logic [3:0] rx1 = 4'h0, rx2 = 4'h0, field, led;
   logic [1:0] s1 = 2'h0, s2 = 2'h0, t1 = 2'h0, t2 = 2'h0;
   logic [2:0] press = 3'h0;
   logic b1_n, b2_n, b3_n, ack, lrst;
   logic [1:0] c_r1, c_r2, c_t1, c_t2, pstd, psel;
   int miscompares = 0, cmp_count = 0, cycles = 0;
   // Expected tables, indexed by standard code or select code
   logic [1:0] col [4] = '{SDISEL_COL_RED, SDISEL_COL_ORG, SDISEL_COL_OFF, SDISEL_COL_GRN};
   logic [1:0] gstd [4] = '{SDISEL_STD_SD, SDISEL_STD_HD, SDISEL_STD_SD, SDISEL_STD_3G};
   logic [3:0] lexp [4] = '{4'hA, 4'h5, 4'hE, 4'hC};
   // ==========================================
   // Instances
   sdisel_board sdisel_board_i (.sw_on_i(sw_on), .press_i(press), .user_switch_field_o(field),
      .full_colorbar_button_n_o(b1_n), .checkfield_button_n_o(b2_n), .logic_reset_button_n_o(b3_n));
   sdisel_top sdisel_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(drd), .wb_ack_o(ack),
      .user_switch_field_i(field), .full_colorbar_button_n_i(b1_n), .checkfield_button_n_i(b2_n),
      .logic_reset_button_n_i(b3_n), .first_input_rx_state_i(rx1), .second_input_rx_state_i(rx2),
      .first_input_rx_standard_i(s1), .second_input_rx_standard_i(s2),
      .first_output_tx_standard_i(t1), .second_output_tx_standard_i(t2), .led_o(led),
      .rx_first_bicolor_o(c_r1), .rx_second_bicolor_o(c_r2), .tx_first_bicolor_o(c_t1),
      .tx_second_bicolor_o(c_t2), .pattern_standard_o(pstd), .pattern_select_o(psel),
      .logic_reset_o(lrst));
   // ==========================================
   // Clock and hang guard; run needs well under a thousand cycles
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         finish_test();
      end
   end
   // ==========================================
   // Shared tasks
   task finish_test();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Three edges: switch capture, generator standard, then its LED view
   task settle();
      repeat (3) @(posedge clk_i);
      #1;
   endtask : settle
   // Classic single cycle, held until ack is sampled
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      adr <= a;
      we <= w;
      wdat <= d;
      sel <= 4'hF;
      cyc <= 1'b1;
      stb <= 1'b1;
      // No fixed latency assumed; the wait ends when ack is seen, and the hang guard catches a missing ack
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rdat = drd;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // Press, check while held, release, check it stays
   task push(input int b, input logic [1:0] e, input logic r);
      @(posedge clk_i);
      press[b] <= 1'b1;
      settle();
      check("psel_held", psel, e);
      check("lrst_held", lrst, r);
      @(posedge clk_i);
      press[b] <= 1'b0;
      settle();
      check("psel_rel", psel, e);
      check("lrst_rel", lrst, 1'b0);
   endtask : push
   // ==========================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      check("psel_dflt", psel, SDISEL_PAT_BAR75);
      @(posedge clk_i);
      rx1 <= 4'hA;
      rx2 <= 4'h5;
      s1 <= 2'h3;
      s2 <= 2'h1;
      // Every display-select code, generator set to 3G
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_i);
         sw_on <= ~{s[1:0], 2'b11};
         settle();
         check("led_sel", led, lexp[s]);
      end
      // Every generator code, unlisted one included
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         sw_on <= ~{2'b11, k[1:0]};
         settle();
         check("pstd", pstd, gstd[k]);
         check("led_gen", led, {gstd[k][0], gstd[k][1], 2'b00});
      end
      // Bi-colour drive, ports given opposite codes to catch swaps
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         s1 <= k[1:0];
         s2 <= ~k[1:0];
         t1 <= k[1:0];
         t2 <= ~k[1:0];
         settle();
         check("rx_d6", c_r1, col[k]);
         check("rx_d1", c_r2, col[3 - k]);
         check("tx_d5", c_t1, col[k]);
         check("tx_d3", c_t2, col[3 - k]);
      end
      push(0, SDISEL_PAT_BAR100, 1'b0);
      push(1, SDISEL_PAT_CHECK, 1'b0);
      push(2, SDISEL_PAT_BAR75, 1'b1);
      // Register path: pattern request, status, soft reset, hole
      wb(1'b1, SDISEL_CTRL_OFS, 32'h1);
      settle();
      check("psel_bus", psel, SDISEL_PAT_BAR100);
      wb(1'b0, SDISEL_STAT_OFS, 32'h0);
      check("status", rdat, 32'h0000_0FDC);
      wb(1'b1, SDISEL_CTRL_OFS, 32'h4);
      settle();
      check("lrst_sw", lrst, 1'b1);
      check("psel_sw", psel, SDISEL_PAT_BAR75);
      wb(1'b0, SDISEL_CTRL_OFS, 32'h0);
      check("ctrl_rd", {29'h0, rdat[2:0]}, 32'h4);
      wb(1'b1, SDISEL_CTRL_OFS, 32'h0);
      settle();
      check("lrst_clr", lrst, 1'b0);
      wb(1'b0, 4'h8, 32'h0);
      check("unmapped", rdat, SDISEL_RD_ZERO);
      // Bus pattern codes: 11 picks checkfield, 10 leaves it alone
      wb(1'b1, SDISEL_CTRL_OFS, 32'h3);
      settle();
      check("psel_bus_chk", psel, SDISEL_PAT_CHECK);
      wb(1'b1, SDISEL_CTRL_OFS, 32'h2);
      settle();
      check("psel_bus_bad", psel, SDISEL_PAT_CHECK);
      // Reset in mid-run: outputs drop to idle, then follow inputs again
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      #1;
      check("psel_rst", psel, SDISEL_PAT_BAR75);
      check("pstd_rst", pstd, SDISEL_STD_SD);
      check("led_rst", led, 4'h0);
      check("d6_rst", c_r1, SDISEL_COL_OFF);
      @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      check("led_back", led, 4'hC);
      check("d6_back", c_r1, SDISEL_COL_GRN);
      finish_test();
   end
endmodule : sdisel_top_tb
